// *** tcr_pkg.sv ***
// Constants, field layout and carrier types of the tuner chip configuration register.
// Assumes one system clock and a host that loads whole 32-bit words by destination address.
// How it works
// - Bit 0 sets threshold comparator output sense
// - Bit 1 forces gain loop to unity
// - Bit 2 sets gain loop error sign
// - Bits 7, 8 gate carrier/resampler offsets
// - Bits 9, 10 enable oscillator accumulator feedback
// - Bits 12-11 pick five sample phase bits
// - Bit 13 continuous or valid-gated phase update
// - Bit 14 holds accumulators zero until cleared
// - Clear reaches six accumulators and counters
package tcr_pkg;

   // ----------------------------------------------------------------
   // Address map and field positions
   // ----------------------------------------------------------------
   localparam logic [3:0] TCR_ADDR_CHIP_CFG = 4'h6; // Destination address
   localparam int TCR_BIT_CMP_SENSE = 0;
   localparam int TCR_BIT_GAIN_OFF = 1;
   localparam int TCR_BIT_ERR_SENSE = 2;
   localparam int TCR_LSB_CAR_WIDTH = 3;
   localparam int TCR_LSB_RES_WIDTH = 5;
   localparam int TCR_BIT_CAR_OFS_EN = 7;
   localparam int TCR_BIT_RES_OFS_EN = 8;
   localparam int TCR_BIT_CAR_RUN = 9;
   localparam int TCR_BIT_RES_RUN = 10;
   localparam int TCR_LSB_PHASE_SEL = 11;
   localparam int TCR_BIT_PHASE_CONT = 13;
   localparam int TCR_BIT_CLEAR = 14;
   localparam logic [31:0] TCR_WRITE_MASK = 32'h0000_7fff; // Reserved bits dropped
   localparam logic [31:0] TCR_RESET_VALUE = 32'h0000_0000;
   localparam int TCR_NUM_CLEARS = 6;
   localparam int TCR_PHASE_W = 5;
   localparam int TCR_PHASE_MSBS = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Decoded control fields of the configuration word
   typedef struct packed {
      logic cmpSense;
      logic gainLoopOff;
      logic errSense;
      logic [1:0] carWidth;
      logic [1:0] resWidth;
      logic carOfsEn;
      logic resOfsEn;
      logic carrierOscAccumRun;
      logic resampOscAccumRun;
      logic [1:0] phaseSel;
      logic phaseCont;
      logic clearAll;
   } tcr_ctrl_t;

   // One clear line for each covered accumulator or counter
   typedef struct packed {
      logic carrierOsc;
      logic cicFilter;
      logic gainLoopFilter;
      logic serialShiftCount;
      logic serialClockLogic;
      logic resampCarryDiv;
   } tcr_clear_t;

   // Keep the top 8/16/24/32 bits of an offset word
   function automatic logic [31:0] tcr_width_mask(input logic [1:0] code);
      unique case (code)
         2'h0: tcr_width_mask = 32'hff00_0000;
         2'h1: tcr_width_mask = 32'hffff_0000;
         2'h2: tcr_width_mask = 32'hffff_ff00;
         2'h3: tcr_width_mask = 32'hffff_ffff;
      endcase
   endfunction : tcr_width_mask

   // Split the stored word into its fields
   function automatic tcr_ctrl_t tcr_decode(input logic [31:0] w);
      tcr_ctrl_t c;
      c.cmpSense = w[TCR_BIT_CMP_SENSE];
      c.gainLoopOff = w[TCR_BIT_GAIN_OFF];
      c.errSense = w[TCR_BIT_ERR_SENSE];
      c.carWidth = w[TCR_LSB_CAR_WIDTH +: 2];
      c.resWidth = w[TCR_LSB_RES_WIDTH +: 2];
      c.carOfsEn = w[TCR_BIT_CAR_OFS_EN];
      c.resOfsEn = w[TCR_BIT_RES_OFS_EN];
      c.carrierOscAccumRun = w[TCR_BIT_CAR_RUN];
      c.resampOscAccumRun = w[TCR_BIT_RES_RUN];
      c.phaseSel = w[TCR_LSB_PHASE_SEL +: 2];
      c.phaseCont = w[TCR_BIT_PHASE_CONT];
      c.clearAll = w[TCR_BIT_CLEAR];
      return c;
   endfunction : tcr_decode

endpackage : tcr_pkg

// *** tcr_phase_sel.sv ***
// Sample phase output selector and its strobe.
// Assumes phase bits and strobe come from the resampler in the same clock domain.
`timescale 1ns/1ps
module tcr_phase_sel
   import tcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [1:0] phaseSel,
   input wire logic phaseCont,
   input wire logic [TCR_PHASE_MSBS-1:0] phaseMsbs,
   input wire logic strobeIn,
   input wire logic outputValidStrobe,
   output logic [TCR_PHASE_W-1:0] samplePhaseOut,
   output logic samplePhaseStrobe
);

   // ----------------------------------------------------------------
   // Selection and update
   // ----------------------------------------------------------------
   logic [TCR_PHASE_MSBS-1:0] shifted; // Window moved down by the select code
   logic updateNow; // Outputs may change this cycle

   assign shifted = phaseMsbs >> phaseSel;
   assign updateNow = phaseCont | outputValidStrobe;

   // Outputs hold between updates so a slow reader sees a stable phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samplePhaseOut <= '0;
         samplePhaseStrobe <= 1'b0;
      end else if (ce && updateNow) begin
         samplePhaseOut <= shifted[TCR_PHASE_W-1:0];
         samplePhaseStrobe <= strobeIn;
      end
   end

endmodule : tcr_phase_sel

// *** tcr_config_reg.sv ***
// Chip configuration register of the tuner and the control it hands the datapaths.
// Assumes the host presents a complete 32-bit word with a one-cycle write strobe.
`timescale 1ns/1ps
module tcr_config_reg
   import tcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic cfgWrite,
   input wire logic [3:0] cfgAddr,
   input wire logic [31:0] cfgWrData,
   input wire logic inputAboveThresh,
   input wire logic outputAboveThresh,
   input wire logic [31:0] carrierOffsetWord,
   input wire logic [31:0] resampOffsetWord,
   input wire logic [TCR_PHASE_MSBS-1:0] resampPhaseMsbs,
   input wire logic resampCarry,
   input wire logic outputValidStrobe,
   output logic [31:0] cfgRdData,
   output logic threshold_compare_out,
   output logic gain_loop_off,
   output logic gainErrPositive,
   output logic [31:0] carrierOffsetUsed,
   output logic [31:0] resampOffsetUsed,
   output logic carrier_osc_accum_run,
   output logic resamp_osc_accum_run,
   output tcr_clear_t accumClear,
   output logic [TCR_PHASE_W-1:0] sample_phase_out,
   output logic sample_phase_strobe
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [31:0] chip_configuration_reg; // Stored word, reserved bits zero
   logic [31:0] chip_configuration_next; // Value after a write
   tcr_ctrl_t ctrl; // Decoded fields
   logic hitWrite; // Write aimed at this register

   assign hitWrite = cfgWrite && (cfgAddr == TCR_ADDR_CHIP_CFG);
   assign chip_configuration_next = cfgWrData & TCR_WRITE_MASK;
   assign ctrl = tcr_decode(chip_configuration_reg);

   // Host write; other addresses belong to other registers and are ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_configuration_reg <= TCR_RESET_VALUE;
      end else if (ce && hitWrite) begin
         chip_configuration_reg <= chip_configuration_next;
      end
   end

   // Readback copy; a flop so the output never glitches on decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgRdData <= TCR_RESET_VALUE;
      end else if (ce) begin
         cfgRdData <= chip_configuration_reg;
      end
   end

   // ----------------------------------------------------------------
   // Level detector and gain loop controls
   // ----------------------------------------------------------------
   // Comparator sense and gain error sign are plain XNOR inversions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         threshold_compare_out <= 1'b0;
         gain_loop_off <= 1'b0;
         gainErrPositive <= 1'b0;
      end else if (ce) begin
         // Sense 1: high above threshold; sense 0: high at or below
         threshold_compare_out <= ~(inputAboveThresh ^ ctrl.cmpSense);
         // Gain loop consumer holds gain at exactly unity while set
         gain_loop_off <= ctrl.gainLoopOff;
         // Error +1 encoded as 1, -1 as 0
         gainErrPositive <= ~(outputAboveThresh ^ ctrl.errSense);
      end
   end

   // ----------------------------------------------------------------
   // Offset frequency words
   // ----------------------------------------------------------------
   // Width trims low bits, enable zeroes the word; both applied here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrierOffsetUsed <= '0;
         resampOffsetUsed <= '0;
      end else if (ce) begin
         // Gated offset: zero when disabled
         if (ctrl.carOfsEn) begin
            carrierOffsetUsed <= carrierOffsetWord & tcr_width_mask(ctrl.carWidth);
         end else begin
            carrierOffsetUsed <= '0;
         end
         if (ctrl.resOfsEn) begin
            resampOffsetUsed <= resampOffsetWord & tcr_width_mask(ctrl.resWidth);
         end else begin
            resampOffsetUsed <= '0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Oscillator accumulators and clear
   // ----------------------------------------------------------------
   // Clear is a level: it lasts exactly as long as the stored bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_osc_accum_run <= 1'b0;
         resamp_osc_accum_run <= 1'b0;
         accumClear <= '0;
      end else if (ce) begin
         carrier_osc_accum_run <= ctrl.carrierOscAccumRun;
         resamp_osc_accum_run <= ctrl.resampOscAccumRun;
         accumClear <= {TCR_NUM_CLEARS{ctrl.clearAll}};
      end
   end

   // ----------------------------------------------------------------
   // Sample phase outputs
   // ----------------------------------------------------------------
   tcr_phase_sel uPhase (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .phaseSel(ctrl.phaseSel),
      .phaseCont(ctrl.phaseCont),
      .phaseMsbs(resampPhaseMsbs),
      .strobeIn(resampCarry),
      .outputValidStrobe(outputValidStrobe),
      .samplePhaseOut(sample_phase_out),
      .samplePhaseStrobe(sample_phase_strobe)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Past terms of the first three checks are qualified by $past(rst_n), so those never reach back into reset
   a_cmp_sense_out: assert property (
      $past(rst_n) && ce && $past(ce) |->
      threshold_compare_out == ($past(inputAboveThresh) == $past(ctrl.cmpSense)))
      else $error("comparator output sense wrong");

   a_gain_unity_hold: assert property (
      $past(rst_n) && $past(ce) |-> gain_loop_off == $past(ctrl.gainLoopOff))
      else $error("gain loop not held off");

   a_err_sign_out: assert property (
      $past(rst_n) && $past(ce) |->
      gainErrPositive == ($past(outputAboveThresh) == $past(ctrl.errSense)))
      else $error("gain error sign wrong");

   a_car_width_mask: assert property (
      $past(ce) && $past(ctrl.carWidth) == 2'h0 |-> carrierOffsetUsed[23:0] == 24'h00_0000)
      else $error("carrier offset not trimmed to 8 bits");

   a_ofs_gate_zero: assert property (
      $past(ce) && !$past(ctrl.resOfsEn) |-> resampOffsetUsed == 32'h0000_0000)
      else $error("resampler offset not zeroed");

   a_accum_run_follow: assert property (
      ce && hitWrite ##1 ce |=> carrier_osc_accum_run == $past(cfgWrData[TCR_BIT_CAR_RUN], 2))
      else $error("carrier accumulator run wrong");

   a_phase_select: assert property (
      ce && ctrl.phaseCont |=> sample_phase_out ==
         5'($past(resampPhaseMsbs) >> $past(ctrl.phaseSel)))
      else $error("sample phase select wrong");

   a_phase_hold: assert property (
      !ctrl.phaseCont && !outputValidStrobe |=> $stable(sample_phase_out))
      else $error("sample phase changed without valid strobe");

   a_clear_held: assert property (
      ce && ctrl.clearAll && !hitWrite ##1 ce |=> accumClear.carrierOsc)
      else $error("clear released without write");

   a_clear_all_six: assert property (
      accumClear == '0 || accumClear == {TCR_NUM_CLEARS{1'b1}})
      else $error("clear lines disagree");

   a_reserved_zero: assert property (
      chip_configuration_reg[31:15] == 17'h0_0000)
      else $error("reserved bits stored");

   c_write_hit: cover property (ce && hitWrite);
   c_clear_cycle: cover property (accumClear.cicFilter ##[1:20] !accumClear.cicFilter);
   c_valid_update: cover property (!ctrl.phaseCont && outputValidStrobe && ce);
   c_gain_off: cover property (gain_loop_off);

endmodule : tcr_config_reg

// *** tb_top.sv ***
// Self-checking bench for the tuner chip configuration register.
// Assumes tcr_pkg is compiled first; the bench drives every port itself, no partner model.
`timescale 1ns/1ps
module tb_top;
   import tcr_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk = 1'b0; // 250 MHz system clock
   logic rst_n = 1'b0; // Active low, held at start
   logic ce = 1'b1; // Left running, except for one frozen stretch at the end of the sequence
   logic cfgWrite = 1'b0;
   logic [3:0] cfgAddr = 4'h0;
   logic [31:0] cfgWrData = 32'h0;
   logic inputAboveThresh = 1'b0;
   logic outputAboveThresh = 1'b0;
   logic [31:0] carrierOffsetWord = 32'h1234_5678; // Distinct bytes expose a wrong trim
   logic [31:0] resampOffsetWord = 32'h9abc_def0;
   logic [7:0] resampPhaseMsbs = 8'h00;
   logic resampCarry = 1'b0;
   logic outputValidStrobe = 1'b0;
   logic [31:0] cfgRdData, carrierOffsetUsed, resampOffsetUsed;
   logic threshold_compare_out, gain_loop_off, gainErrPositive;
   logic carrier_osc_accum_run, resamp_osc_accum_run, sample_phase_strobe;
   logic [4:0] sample_phase_out;
   tcr_clear_t accumClear;
   int nMismatch = 0; // Failed comparisons
   int nTests = 0; // All comparisons
   logic [31:0] msk; // Expected width mask

   // Clock: invert every half period
   always #2 clk = ~clk;

   tcr_config_reg tcr_config_reg_i (.clk(clk), .rst_n(rst_n), .ce(ce), .cfgWrite(cfgWrite),
      .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .inputAboveThresh(inputAboveThresh),
      .outputAboveThresh(outputAboveThresh), .carrierOffsetWord(carrierOffsetWord),
      .resampOffsetWord(resampOffsetWord), .resampPhaseMsbs(resampPhaseMsbs),
      .resampCarry(resampCarry), .outputValidStrobe(outputValidStrobe), .cfgRdData(cfgRdData),
      .threshold_compare_out(threshold_compare_out), .gain_loop_off(gain_loop_off),
      .gainErrPositive(gainErrPositive), .carrierOffsetUsed(carrierOffsetUsed),
      .resampOffsetUsed(resampOffsetUsed), .carrier_osc_accum_run(carrier_osc_accum_run),
      .resamp_osc_accum_run(resamp_osc_accum_run), .accumClear(accumClear),
      .sample_phase_out(sample_phase_out), .sample_phase_strobe(sample_phase_strobe));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compare and count; four-state equality so X never matches
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   // One-cycle write; returns once derived outputs reflect it (one edge after the take)
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cfgWrite <= 1'b1;
      cfgAddr <= a;
      cfgWrData <= d;
      @(posedge clk);
      cfgWrite <= 1'b0;
      @(posedge clk);
      #1;
   endtask : wr

   // Let one sampling edge pass after inputs changed, then look
   task settle;
      @(posedge clk);
      #1;
   endtask : settle

   // Verdict, reached by the main sequence and the watchdog alike
   task results;
      $display("checks %0d, mismatches %0d", nTests, nMismatch);
      if (nMismatch == 0 && nTests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // Watchdog: whole run is under two hundred cycles, so 20 us means a hang
   initial begin
      #20000;
      nMismatch++;
      results();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk("reset word", 32'h0, cfgRdData);
      chk("reset clear", 32'h0, accumClear);
      // Reserved bits dropped, all clears asserted together
      wr(4'h6, 32'hffff_ffff);
      chk("readback", 32'h0000_7fff, cfgRdData);
      chk("clear lines", 32'h3f, accumClear);
      // Another address must leave the word alone
      wr(4'h7, 32'h0);
      chk("other addr", 32'h0000_7fff, cfgRdData);
      // Comparator sense, gain disable and error sign over all combinations
      for (int i = 0; i < 16; i++) begin
         wr(4'h6, {29'h0, i[2:0]});
         @(posedge clk);
         inputAboveThresh <= i[3];
         outputAboveThresh <= i[3];
         settle();
         chk("cmp out", {31'h0, ~(i[3] ^ i[0])}, threshold_compare_out);
         chk("gain off", {31'h0, i[1]}, gain_loop_off);
         chk("err sign", {31'h0, ~(i[3] ^ i[2])}, gainErrPositive);
      end
      // Width codes with each enable on and off; the top bits are kept
      for (int i = 0; i < 8; i++) begin
         msk = 32'hffff_ffff << (24 - 8 * i[1:0]);
         wr(4'h6, {23'h0, i[2], i[2], i[1:0], i[1:0], 3'h0});
         chk("car ofs", i[2] ? carrierOffsetWord & msk : 32'h0, carrierOffsetUsed);
         chk("res ofs", i[2] ? resampOffsetWord & msk : 32'h0, resampOffsetUsed);
      end
      // Accumulator feedback enables, one at a time
      wr(4'h6, 32'h0000_0200);
      chk("car run", 32'h1, carrier_osc_accum_run);
      chk("res run", 32'h0, resamp_osc_accum_run);
      wr(4'h6, 32'h0000_0400);
      chk("car run", 32'h0, carrier_osc_accum_run);
      chk("res run", 32'h1, resamp_osc_accum_run);
      // Phase selection in continuous mode, every code
      @(posedge clk);
      resampPhaseMsbs <= 8'hb6;
      for (int i = 0; i < 4; i++) begin
         wr(4'h6, {18'h0, 1'b1, i[1:0], 11'h0});
         @(posedge clk);
         resampCarry <= i[0];
         settle();
         chk("phase", {27'h0, 5'((8'hb6 >> i))}, sample_phase_out);
         chk("strobe", {31'h0, i[0]}, sample_phase_strobe);
      end
      // Gated mode: hold without the valid strobe, follow with it
      wr(4'h6, 32'h0000_0000);
      @(posedge clk);
      resampPhaseMsbs <= 8'h4d;
      resampCarry <= 1'b0;
      repeat (2) settle();
      chk("phase hold", 32'h16, sample_phase_out);
      chk("strobe hold", 32'h1, sample_phase_strobe);
      @(posedge clk);
      outputValidStrobe <= 1'b1;
      settle();
      chk("phase gated", 32'h0d, sample_phase_out);
      chk("strobe gated", 32'h0, sample_phase_strobe);
      outputValidStrobe <= 1'b0;
      // Clear stays on across other writes until bit 14 is written as zero
      wr(4'h6, 32'h0000_4000);
      chk("clear on", 32'h3f, accumClear);
      repeat (5) settle();
      chk("clear held", 32'h3f, accumClear);
      wr(4'h6, 32'h0000_4600);
      chk("clear kept", 32'h3f, accumClear);
      wr(4'h6, 32'h0000_0600);
      chk("clear off", 32'h0, accumClear);
      chk("readback", 32'h0000_0600, cfgRdData);
      // Clock enable low: a write made meanwhile must leave no trace
      @(posedge clk);
      ce <= 1'b0;
      wr(4'h6, 32'h0000_0001);
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) settle();
      chk("frozen word", 32'h0000_0600, cfgRdData);
      results();
   end

endmodule : tb_top
